// ### hw/rtc_alarm_pkg.sv
package rtc_alarm_pkg;

  // ********************************************************
  // Register indices (byte address is four times the index)
  // ********************************************************
  localparam logic [3:0] IDX_MINUTE_COUNTER    = 4'h1;
  localparam logic [3:0] IDX_HOUR_COUNTER      = 4'h2;
  localparam logic [3:0] IDX_WEEKDAY_COUNTER   = 4'h3;
  localparam logic [3:0] IDX_DATE_COUNTER      = 4'h4;
  localparam logic [3:0] IDX_MINUTE_ALARM      = 4'h8;
  localparam logic [3:0] IDX_HOUR_ALARM        = 4'h9;
  localparam logic [3:0] IDX_WDAY_DATE_ALARM   = 4'hA;
  localparam logic [3:0] IDX_EXTENSION_CONTROL = 4'hD;
  localparam logic [3:0] IDX_EVENT_FLAGS       = 4'hE;
  localparam logic [3:0] IDX_INTERRUPT_CONTROL = 4'hF;

  // ********************************************************
  // Field positions and masks
  // ********************************************************
  localparam int EXCLUDE_BIT       = 7;
  localparam int TARGET_SELECT_BIT = 6;
  localparam int ALARM_FLAG_BIT    = 3;
  localparam int TIMER_FLAG_BIT    = 4;
  localparam int UPDATE_FLAG_BIT   = 5;
  localparam int ALARM_IE_BIT      = 3;
  localparam int TIMER_IE_BIT      = 4;
  localparam int UPDATE_IE_BIT     = 5;
  localparam int STOP_BIT          = 1;
  localparam int RESET_BIT         = 0;

  localparam logic [7:0] MINUTE_MASK   = 8'h7F;
  localparam logic [7:0] HOUR_MASK     = 8'h3F;
  localparam logic [7:0] DATE_MASK     = 8'h3F;
  localparam logic [7:0] WEEKDAY_MASK  = 8'h7F;
  localparam logic [7:0] EXT_MASK      = 8'hF3;
  localparam logic [7:0] FLAGS_MASK    = 8'h3A;
  localparam logic [7:0] CONTROL_MASK  = 8'h3B;
  localparam logic [7:0] ALARM_MASK    = 8'hFF;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // ********************************************************
  // Bus answer constants
  // ********************************************************
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Match-side state handed to the comparator
  typedef struct packed {
    logic [7:0] minute;
    logic [7:0] hour;
    logic [7:0] weekday;
    logic [7:0] date;
  } time_now_t;

endpackage

// ### hw/alarm_match_if.sv
`timescale 1ns/10ps
// Carries alarm settings and current time to the comparator
interface alarm_match_if;
  import rtc_alarm_pkg::*;
  logic [7:0] minuteAlarm;
  logic [7:0] hourAlarm;
  logic [7:0] wdayDateAlarm;
  logic       targetDate;
  time_now_t  timeNow;
  logic       match;

  modport ctrl (output minuteAlarm, output hourAlarm, output wdayDateAlarm,
                output targetDate, output timeNow, input match);
  modport cmp  (input minuteAlarm, input hourAlarm, input wdayDateAlarm,
                input targetDate, input timeNow, output match);
endinterface

// ### hw/rtc_alarm_compare.sv
`timescale 1ns/10ps
// Combinational alarm comparison of time against alarm fields
module rtc_alarm_compare
  import rtc_alarm_pkg::*;
(
  // Settings and time
  alarm_match_if.cmp mif
);

  // ********************************************************
  // Field compare
  // ********************************************************
  function automatic logic fieldHit(input logic [7:0] alarm, input logic [7:0] now,
                                    input logic [7:0] mask);
    fieldHit = alarm[EXCLUDE_BIT] || ((alarm & mask) == (now & mask));
  endfunction

  logic minHit;
  logic hourHit;
  logic dayHit;

  // Minute and hour compare, weekday or date by target select
  always_comb begin
    minHit  = fieldHit(mif.minuteAlarm, mif.timeNow.minute, MINUTE_MASK); // R13 R15
    hourHit = fieldHit(mif.hourAlarm, mif.timeNow.hour, HOUR_MASK);       // R15 R16
    if (mif.wdayDateAlarm[EXCLUDE_BIT]) begin
      dayHit = 1'b1;                                                      // R13
    end else if (mif.targetDate) begin
      dayHit = fieldHit(mif.wdayDateAlarm, mif.timeNow.date, DATE_MASK);  // R11 R16
    end else begin
      dayHit = |(mif.wdayDateAlarm & mif.timeNow.weekday & WEEKDAY_MASK); // R11 R12
    end
    mif.match = minHit && hourHit && dayHit;                              // R01 R14
  end

endmodule

// ### hw/rtc_alarm_match_interrupt.sv
// Operation
// R01: Matching enabled alarm fields raise an event
// R02: Event only when counters move into match
// R03: Event sets sticky flag bit 3
// R04: Writing one to flag does nothing
// R05: Enabled event holds interrupt low
// R06: Clearing enable releases the interrupt
// R07: Clearing flag releases the interrupt
// R08: Disabled event sets flag, pin released
// R09: With flag set, enable steers the pin
// R10: Stop or reset bit suppresses events
// R11: Target select picks weekday or date
// R12: Weekday bits: any selected day matches
// R13: Exclude bit drops field from compare
// R14: All excluded gives event every minute
// R15: Alarm fields are BCD like counters
// R16: Hour/date bit 6 is plain storage
// R17: Fixed zero bits ignore writes, read zero
// R18: Host clears enable before programming alarm
// R19: Alarm as storage needs enable kept zero
// R20: Other sources still hold the pin
// R21: Pin low when any source request active
`timescale 1ns/10ps
module rtc_alarm_match_interrupt
  import rtc_alarm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Running time counters (from timekeeping, same clock)
  input  wire logic [7:0]  minuteCount,
  input  wire logic [7:0]  hourCount,
  input  wire logic [7:0]  weekdayCount,
  input  wire logic [7:0]  dateCount,
  // Other interrupt sources (same clock)
  input  wire logic        timerEvent,
  input  wire logic        updateEvent,
  input  wire logic        timerIrqReq,
  input  wire logic        updateIrqReq,
  // Control outputs toward the timekeeping core
  output logic             stopCount,
  output logic             resetCount,
  output logic [7:0]       extensionCtrl,
  // Open-drain interrupt pin, active low
  output logic             irqOut,
  output logic             irqOe
);

  // ********************************************************
  // Register state
  // ********************************************************
  logic [7:0] minAlarm_ff,  nxt_minAlarm;
  logic [7:0] hourAlarm_ff, nxt_hourAlarm;
  logic [7:0] dayAlarm_ff,  nxt_dayAlarm;
  logic [7:0] ext_ff,       nxt_ext;
  logic [7:0] flags_ff,     nxt_flags;
  logic [7:0] ctrl_ff,      nxt_ctrl;
  logic       primed_ff,    nxt_primed;
  time_now_t  prevTime_ff,  nxt_prevTime;
  logic [31:0] rdata_ff,    nxt_rdata;
  logic        err_ff,      nxt_err;

  logic        wrEn;
  logic        rdEn;
  logic [3:0]  regIdx;
  logic        addrOk;
  logic        alarmEvent;
  logic        alarmReq;
  logic        otherReq;
  logic        wrMinAlarm;
  logic        wrHourAlarm;
  logic        wrDayAlarm;
  logic        wrExt;
  logic        wrCtrl;
  logic        wrFlags;

  alarm_match_if mif ();

  // ********************************************************
  // Comparator
  // ********************************************************
  rtc_alarm_compare u_compare (
    .mif (mif)
  );

  // Feed the comparator
  assign mif.minuteAlarm    = minAlarm_ff;
  assign mif.hourAlarm      = hourAlarm_ff;
  assign mif.wdayDateAlarm  = dayAlarm_ff;
  assign mif.targetDate     = ext_ff[TARGET_SELECT_BIT];                  // R11
  assign mif.timeNow.minute  = minuteCount;
  assign mif.timeNow.hour    = hourCount;
  assign mif.timeNow.weekday = weekdayCount;
  assign mif.timeNow.date    = dateCount;

  // ********************************************************
  // APB decode
  // ********************************************************
  function automatic logic isMapped(input logic [3:0] idx);
    isMapped = (idx == IDX_MINUTE_COUNTER) || (idx == IDX_HOUR_COUNTER)
            || (idx == IDX_WEEKDAY_COUNTER) || (idx == IDX_DATE_COUNTER)
            || (idx == IDX_MINUTE_ALARM) || (idx == IDX_HOUR_ALARM)
            || (idx == IDX_WDAY_DATE_ALARM) || (idx == IDX_EXTENSION_CONTROL)
            || (idx == IDX_EVENT_FLAGS) || (idx == IDX_INTERRUPT_CONTROL);
  endfunction

  // Byte address to word index; upper bits must be zero
  // Every register sits in the low byte of its own aligned word.
  // A misaligned or unmapped address answers with an error and
  // leaves every register untouched.
  assign regIdx = paddr[5:2];
  assign addrOk = isMapped(regIdx) && (paddr[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
  assign wrEn   = psel && penable && pwrite && addrOk;
  assign rdEn   = psel && !penable && !pwrite;
  assign pready = 1'b1;

  // ********************************************************
  // Write strobes, one per writable register
  // ********************************************************
  // A strobe is high only in the access phase of a mapped write,
  // which is the single edge at which the write takes effect.
  // The counters at indices one to four get no strobe, so writes
  // there are dropped without side effects.
  function automatic logic isWrite(input logic       en,
                                   input logic [3:0] at,
                                   input logic [3:0] idx);
    isWrite = en && (at == idx);
  endfunction

  // Decode of the write target
  assign wrMinAlarm  = isWrite(wrEn, regIdx, IDX_MINUTE_ALARM);
  assign wrHourAlarm = isWrite(wrEn, regIdx, IDX_HOUR_ALARM);
  assign wrDayAlarm  = isWrite(wrEn, regIdx, IDX_WDAY_DATE_ALARM);
  assign wrExt       = isWrite(wrEn, regIdx, IDX_EXTENSION_CONTROL);
  assign wrCtrl      = isWrite(wrEn, regIdx, IDX_INTERRUPT_CONTROL);
  assign wrFlags     = isWrite(wrEn, regIdx, IDX_EVENT_FLAGS);

  // ********************************************************
  // Alarm event: time moves into a match, not while stopped
  // ********************************************************
  // The time seen one cycle ago is kept, so a write that makes the
  // alarm fields equal to the present time raises no event; only an
  // advance of the counters can start one.
  // The history is not trusted in the first cycle after reset, so a
  // time that already matches at release gives no event either.
  // With every field excluded the match is always true, and the
  // event then follows each advance of the minute counter.

  // Next history values: always the present time
  always_comb begin
    nxt_prevTime = mif.timeNow;
    nxt_primed   = 1'b1;
  end

  // Event needs a primed history, a moved time and a match
  always_comb begin
    alarmEvent = primed_ff && (mif.timeNow != prevTime_ff) && mif.match  // R01 R02 R14
              && !ctrl_ff[STOP_BIT] && !ctrl_ff[RESET_BIT];               // R10
  end

  // Time history register
  always_ff @(posedge clk) begin
    if (srst) begin
      prevTime_ff <= {4{BYTE_ZERO}};
      primed_ff   <= 1'b0;
    end else begin
      prevTime_ff <= nxt_prevTime;
      primed_ff   <= nxt_primed;
    end
  end

  // ********************************************************
  // Alarm field writes
  // ********************************************************
  // All eight bits are storage; bit 6 of hour, and of date while target select picks
  // date, is kept but not compared; in weekday mode bit 6 is a weekday bit.
  always_comb begin
    nxt_minAlarm  = minAlarm_ff;
    nxt_hourAlarm = hourAlarm_ff;
    nxt_dayAlarm  = dayAlarm_ff;
    if (wrMinAlarm) begin
      nxt_minAlarm = pwdata[7:0] & ALARM_MASK;                            // R13 R15
    end
    if (wrHourAlarm) begin
      nxt_hourAlarm = pwdata[7:0] & ALARM_MASK;                           // R16
    end
    if (wrDayAlarm) begin
      nxt_dayAlarm = pwdata[7:0] & ALARM_MASK;                            // R12 R16
    end
  end

  // ********************************************************
  // Extension and control writes
  // ********************************************************
  // Fixed zero bits are masked on the way in, so they read back
  // as zero and never reach the timekeeping core.
  always_comb begin
    nxt_ext  = ext_ff;
    nxt_ctrl = ctrl_ff;
    if (wrExt) begin
      nxt_ext = pwdata[7:0] & EXT_MASK;                                   // R11 R17
    end
    if (wrCtrl) begin
      nxt_ctrl = pwdata[7:0] & CONTROL_MASK;                              // R10 R17
    end
  end

  // ********************************************************
  // Event flags
  // ********************************************************
  // Software can only clear a flag; hardware sets it.
  // Hardware set wins over a clear in the same cycle, so an event
  // that lands on the clearing write is never lost.
  always_comb begin
    nxt_flags = flags_ff;
    if (wrFlags) begin
      // Only zero clears; a one leaves the flag alone
      nxt_flags = flags_ff & (pwdata[7:0] | ~FLAGS_MASK) & FLAGS_MASK;    // R04 R17
    end
    if (alarmEvent) begin
      nxt_flags[ALARM_FLAG_BIT] = 1'b1;                                   // R03 R08
    end
    if (timerEvent) begin
      nxt_flags[TIMER_FLAG_BIT] = 1'b1;
    end
    if (updateEvent) begin
      nxt_flags[UPDATE_FLAG_BIT] = 1'b1;
    end
  end

  // ********************************************************
  // Read data and error answer
  // ********************************************************
  always_comb begin
    nxt_rdata = rdata_ff;
    nxt_err   = 1'b0;
    if (psel && !penable) begin
      nxt_err   = !addrOk;
      nxt_rdata = WORD_ZERO;
      if (rdEn && addrOk) begin
        unique case (regIdx)
          IDX_MINUTE_COUNTER:    nxt_rdata[7:0] = minuteCount & MINUTE_MASK;
          IDX_HOUR_COUNTER:      nxt_rdata[7:0] = hourCount & HOUR_MASK;
          IDX_WEEKDAY_COUNTER:   nxt_rdata[7:0] = weekdayCount & WEEKDAY_MASK;
          IDX_DATE_COUNTER:      nxt_rdata[7:0] = dateCount & DATE_MASK;
          IDX_MINUTE_ALARM:      nxt_rdata[7:0] = minAlarm_ff;
          IDX_HOUR_ALARM:        nxt_rdata[7:0] = hourAlarm_ff;
          IDX_WDAY_DATE_ALARM:   nxt_rdata[7:0] = dayAlarm_ff;
          IDX_EXTENSION_CONTROL: nxt_rdata[7:0] = ext_ff;
          IDX_EVENT_FLAGS:       nxt_rdata[7:0] = flags_ff;
          IDX_INTERRUPT_CONTROL: nxt_rdata[7:0] = ctrl_ff;
          default:               nxt_rdata[7:0] = BYTE_ZERO;
        endcase
      end
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  // Alarm field registers
  always_ff @(posedge clk) begin
    if (srst) begin
      minAlarm_ff  <= BYTE_ZERO;
      hourAlarm_ff <= BYTE_ZERO;
      dayAlarm_ff  <= BYTE_ZERO;
    end else begin
      minAlarm_ff  <= nxt_minAlarm;
      hourAlarm_ff <= nxt_hourAlarm;
      dayAlarm_ff  <= nxt_dayAlarm;
    end
  end

  // Extension and control registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_ff  <= BYTE_ZERO;
      ctrl_ff <= BYTE_ZERO;
    end else begin
      ext_ff  <= nxt_ext;
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Flag register
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_ff <= BYTE_ZERO;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // Read answer and error registers
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= WORD_ZERO;
      err_ff   <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  // ********************************************************
  // Interrupt pin
  // ********************************************************
  // Alarm request follows flag and enable with no auto release
  assign alarmReq = flags_ff[ALARM_FLAG_BIT] && ctrl_ff[ALARM_IE_BIT];    // R05 R06 R07 R09
  // Requests of the timer and update sources
  assign otherReq = timerIrqReq || updateIrqReq;
  // Open drain: any source pulls the pin low.
  // Clearing the alarm enable or flag drops only the alarm's share;
  // the pin stays low while another source still asks for it.
  // The pin data is always low, only the enable moves.
  assign irqOe  = alarmReq || otherReq;                                   // R20 R21
  assign irqOut = 1'b0;

  // ********************************************************
  // Bus answer and controls toward the core
  // ********************************************************

  assign prdata        = rdata_ff;
  assign pslverr       = err_ff && psel && penable;
  assign stopCount     = ctrl_ff[STOP_BIT];
  assign resetCount    = ctrl_ff[RESET_BIT];
  assign extensionCtrl = ext_ff;

endmodule

// ### test/irq_pin_host.sv
`timescale 1ns/10ps
// Host end of the open-drain interrupt line, pulled up
module irq_pin_host (
  // Pin from the block
  input  wire logic irqOut,
  input  wire logic irqOe,
  // Level the host sees
  output logic      irqLow
);
  // Pull-up gives high whenever nobody drives
  assign irqLow = irqOe & ~irqOut;
endmodule

// ### test/rtc_alarm_properties.sv
`timescale 1ns/10ps
// Port-level checks of the alarm block
module rtc_alarm_props (
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Sources and pin
  input wire logic        timerIrqReq,
  input wire logic        updateIrqReq,
  input wire logic        stopCount,
  input wire logic        irqOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic other;
  logic acc;
  logic rdAcc;
  // Helper terms
  assign other = timerIrqReq | updateIrqReq;
  assign acc   = psel & penable & pwrite;
  assign rdAcc = psel & penable & ~pwrite;
  // ********************************************************
  // Assertions
  // ********************************************************
  zero_wait_a: assert property (psel && penable |-> pready) else $error("access stalled");
  src_or_a: assert property (other |-> irqOe) else $error("source not on pin");
  flag_clr_a: assert property (acc && paddr == 12'h038 && !pwdata[3] |=> irqOe == other)
    else $error("flag clear kept pin");
  ena_clr_a: assert property (acc && paddr == 12'h03C && !pwdata[3] |=> irqOe == other)
    else $error("enable clear wrong pin");
  irq_hold_a: assert property (irqOe && !(acc && paddr[11:3] == 9'h007)
    |=> irqOe || $fell(other)) else $error("pin released alone");
  stop_bit_a: assert property (acc && paddr == 12'h03C |=> stopCount == $past(pwdata[1]))
    else $error("stop bit not stored");
  ctl_zero_a: assert property (rdAcc && paddr == 12'h03C |-> (prdata & 32'h000000C4) == 0)
    else $error("control zero bits");
  flg_zero_a: assert property (rdAcc && paddr == 12'h038 |-> (prdata & 32'h000000C5) == 0)
    else $error("flag zero bits");
  upper_zero_a: assert property (prdata[31:8] == 24'h000000) else $error("upper read bits");
  unmapped_err_a: assert property (psel && penable && paddr == 12'h014 |-> pslverr)
    else $error("no error on hole");
endmodule
bind rtc_alarm_match_interrupt rtc_alarm_props u_rtc_alarm_props (.clk(clk), .srst(srst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .timerIrqReq(timerIrqReq),
  .updateIrqReq(updateIrqReq), .stopCount(stopCount), .irqOe(irqOe));

// ### test/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, irqOut, irqOe, irqLow;
  logic        timerEvent, updateEvent, timerIrqReq, updateIrqReq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  minuteCount, hourCount, weekdayCount, dateCount, extensionCtrl, q;
  int          miscompares, checksDone;
  localparam logic [11:0] A_MIN = 12'h020, A_HR = 12'h024, A_WD = 12'h028;
  localparam logic [11:0] A_EXT = 12'h034, A_FLG = 12'h038, A_CTL = 12'h03C;
  rtc_alarm_match_interrupt u_rtc_alarm_match_interrupt (.clk(clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .minuteCount(minuteCount),
    .hourCount(hourCount), .weekdayCount(weekdayCount), .dateCount(dateCount),
    .timerEvent(timerEvent), .updateEvent(updateEvent), .timerIrqReq(timerIrqReq),
    .updateIrqReq(updateIrqReq), .stopCount(), .resetCount(),
    .extensionCtrl(extensionCtrl), .irqOut(irqOut), .irqOe(irqOe));
  irq_pin_host u_irq_pin_host (.irqOut(irqOut), .irqOe(irqOe), .irqLow(irqLow));
  // ********************************************************
  // Bus, time and compare helpers
  // ********************************************************
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    checksDone++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string n);
    apb(1'b0, a, 8'h00);
    check(n, q, e);
  endtask
  task automatic irq(input logic e);
    @(negedge clk);
    check("irq", {7'h00, irqLow}, {7'h00, e});
  endtask
  task automatic tset(input logic [31:0] t);
    @(posedge clk);
    {minuteCount, hourCount, weekdayCount, dateCount} <= t;
    repeat (3) @(posedge clk);
  endtask
  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_regs;
    wr(A_CTL, 8'hFF);
    rd(A_CTL, 8'h3B, "ctl");
    wr(A_FLG, 8'hC5);
    rd(A_FLG, 8'h00, "flg");
    wr(A_HR, 8'h40);
    rd(A_HR, 8'h40, "hr");
    wr(A_EXT, 8'hFF);
    rd(A_EXT, 8'hF3, "ext");
    check("extout", extensionCtrl, 8'hF3);
    wr(A_WD, 8'h40);
    rd(A_WD, 8'h40, "date");
    apb(1'b0, 12'h014, 8'h00);
    wr(A_CTL, 8'h00);
  endtask
  task automatic t_enabled;
    wr(A_EXT, 8'h00);
    wr(A_MIN, 8'h30);
    wr(A_HR, 8'h07);
    wr(A_WD, 8'h80);
    wr(A_CTL, 8'h08);
    repeat (4) @(posedge clk);
    rd(A_FLG, 8'h00, "now");
    tset(32'h2907_0201);
    tset(32'h3007_0201);
    rd(A_FLG, 8'h08, "hit");
    irq(1'b1);
    wr(A_FLG, 8'h08);
    rd(A_FLG, 8'h08, "one");
    wr(A_CTL, 8'h00);
    irq(1'b0);
    wr(A_CTL, 8'h08);
    irq(1'b1);
    wr(A_FLG, 8'h00);
    irq(1'b0);
    tset(32'h2908_0201);
    tset(32'h3008_0201);
    rd(A_FLG, 8'h00, "hour");
    wr(A_CTL, 8'h00);
    tset(32'h2907_0201);
    tset(32'h3007_0201);
    rd(A_FLG, 8'h08, "off");
    irq(1'b0);
    wr(A_FLG, 8'h00);
  endtask
  task automatic t_suppress;
    for (int i = 0; i < 2; i++) begin
      wr(A_CTL, i ? 8'h09 : 8'h0A);
      tset(32'h2907_0201);
      tset(32'h3007_0201);
      rd(A_FLG, 8'h00, "stop");
      irq(1'b0);
    end
    wr(A_CTL, 8'h00);
  endtask
  task automatic t_target;
    wr(A_WD, 8'h05);
    wr(A_MIN, 8'h80);
    wr(A_HR, 8'h80);
    tset(32'h2907_0401);
    rd(A_FLG, 8'h08, "wday");
    wr(A_FLG, 8'h00);
    wr(A_EXT, 8'h40);
    repeat (3) @(posedge clk);
    rd(A_FLG, 8'h00, "ign");
    tset(32'h2907_0405);
    rd(A_FLG, 8'h08, "date");
    wr(A_WD, 8'h80);
    wr(A_EXT, 8'h00);
    wr(A_FLG, 8'h00);
    tset(32'h3007_0405);
    rd(A_FLG, 8'h08, "every");
  endtask
  task automatic t_others;
    wr(A_CTL, 8'h08);
    irq(1'b1);
    @(posedge clk);
    timerIrqReq <= 1'b1;
    wr(A_CTL, 8'h00);
    irq(1'b1);
    @(posedge clk);
    timerIrqReq <= 1'b0;
    irq(1'b0);
    @(posedge clk);
    updateIrqReq <= 1'b1;
    irq(1'b1);
    @(posedge clk);
    timerEvent <= 1'b1;
    @(posedge clk);
    timerEvent <= 1'b0;
    rd(A_FLG, 8'h18, "tflag");
  endtask
  task automatic final_report;
    $display("mismatches %0d checks %0d", miscompares, checksDone);
    if (miscompares == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ********************************************************
  // Clock, sequence and watchdog
  // ********************************************************
  always #20 clk = ~clk;
  initial begin
    {clk, srst, psel, penable, pwrite} = 5'b01000;
    {timerEvent, updateEvent, timerIrqReq, updateIrqReq} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {minuteCount, hourCount, weekdayCount, dateCount} = 32'h3007_0201;
    miscompares = 0;
    checksDone = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_enabled;
    t_suppress;
    t_target;
    t_others;
    final_report;
  end
  initial begin
    #100000;
    miscompares++;
    final_report;
  end
endmodule
